// *** bench/gop_far_model.sv ***
// far-side model: wired equipment on the gpio pins and the occupancy sensor
`timescale 1ns/10ps
`default_nettype none
module gop_far_model
  import gop_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] gpio_out_i,
  input  wire logic [NUM_PINS-1:0] gpio_oe_i,
  input  wire logic [NUM_PINS-1:0] ext_lvl_i,
  input  wire logic                sensor_lvl_i,
  output logic [NUM_PINS-1:0]      gpio_in_o,
  output logic                     ocs_in_o
);
  // wire level: device drive wins where enabled, else the equipment drives
  assign gpio_in_o = (gpio_oe_i & gpio_out_i) | (~gpio_oe_i & ext_lvl_i);
  // sensor output follows the sensed room state
  assign ocs_in_o  = sensor_lvl_i;
endmodule : gop_far_model
`default_nettype wire

// *** bench/tb_gop_pins.sv ***
// self-checking bench for the gpio and occupancy block
`timescale 1ns/10ps
`default_nettype none
`define GOP_CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb_gop_pins;
  import gop_pkg::*;
  localparam int unsigned SEC_P = 10;
  logic core_clk_i = 1'b0, rst_b_i = 1'b0, dir_val_i = 1'b0, lvl_val_i = 1'b0, timed_val_i = 1'b0;
  logic pol_wr_i = 1'b0, pol_val_i = 1'b0, sensor_lvl = 1'b0, ocs_in_i;
  logic [NUM_PINS-1:0] dir_wr_i = '0, lvl_wr_i = '0, timed_wr_i = '0, toggle_i = '0, ext_lvl = 2'h2;
  logic [NUM_PINS-1:0] gpio_in_i, dir_o, gpio_out_o, gpio_oe_o, pin_level_o, timed_busy_o;
  logic [TIME_W-1:0]   timed_sec_i = '0;
  logic                occupancy_polarity_o, ocs_level_o, occupied_o, timed_err_o;
  int                  err_total = 0, cmp_count = 0, cyc = 0;
  gop_pins #(.SEC_CYCLES_P(SEC_P)) DUT (.core_clk_i, .rst_b_i, .dir_wr_i, .dir_val_i, .lvl_wr_i, .lvl_val_i,
    .timed_wr_i, .timed_val_i, .timed_sec_i, .toggle_i, .gpio_in_i, .pol_wr_i, .pol_val_i, .ocs_in_i,
    .dir_o, .gpio_out_o, .gpio_oe_o, .pin_level_o, .timed_busy_o, .occupancy_polarity_o, .ocs_level_o,
    .occupied_o, .timed_err_o);
  gop_far_model far (.gpio_out_i(gpio_out_o), .gpio_oe_i(gpio_oe_o), .ext_lvl_i(ext_lvl),
    .sensor_lvl_i(sensor_lvl), .gpio_in_o(gpio_in_i), .ocs_in_o(ocs_in_i));
  // 25 MHz clock
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask : tick
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // each command lets an idle edge pass first, so no strobe drops and rises in one step
  task automatic cmd_dir(input logic [1:0] m, input logic v);
    tick();
    dir_wr_i  = m;
    dir_val_i = v;
    tick();
    dir_wr_i  = '0;
  endtask : cmd_dir
  task automatic cmd_lvl(input logic [1:0] m, input logic v);
    tick();
    lvl_wr_i  = m;
    lvl_val_i = v;
    tick();
    lvl_wr_i  = '0;
  endtask : cmd_lvl
  task automatic cmd_timed(input logic [1:0] m, input logic v, input logic [6:0] s);
    tick();
    timed_wr_i  = m;
    timed_val_i = v;
    timed_sec_i = s;
    tick();
    timed_wr_i  = '0;
  endtask : cmd_timed
  task automatic cmd_tog(input logic [1:0] m);
    tick();
    toggle_i = m;
    tick();
    toggle_i = '0;
  endtask : cmd_tog
  task automatic cmd_pol(input logic v);
    tick();
    pol_wr_i  = 1'b1;
    pol_val_i = v;
    tick();
    pol_wr_i  = 1'b0;
  endtask : cmd_pol
  // cycle ceiling against hangs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc >= 2000) begin
      $display("Error %0t: cycle limit reached", $time);
      err_total++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    tick(8);
    `GOP_CHK(occupancy_polarity_o, 1'b1)
    `GOP_CHK({dir_o, gpio_oe_o, gpio_out_o, timed_busy_o}, 8'h00)
    rst_b_i = 1'b1;
    cmd_dir(2'h3, 1'b1);
    `GOP_CHK({dir_o, gpio_oe_o}, 4'hf)
    cmd_dir(2'h2, 1'b0);
    `GOP_CHK({dir_o, gpio_oe_o}, 4'h5)
    cmd_lvl(2'h1, 1'b1);
    `GOP_CHK(gpio_out_o, 2'h1)
    tick(2);
    `GOP_CHK(pin_level_o, 2'h3)
    cmd_tog(2'h3);
    `GOP_CHK(gpio_out_o, 2'h2)
    cmd_timed(2'h1, 1'b1, 7'h02);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h7)
    // two seconds are exactly 2*SEC_P cycles
    tick(19);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h7)
    tick();
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h2)
    cmd_timed(2'h1, 1'b1, 7'h00);
    `GOP_CHK({timed_err_o, timed_busy_o}, 3'h4)
    cmd_timed(2'h1, 1'b1, 7'h79);
    `GOP_CHK({timed_err_o, timed_busy_o}, 3'h4)
    cmd_timed(2'h1, 1'b1, 7'h78);
    `GOP_CHK({timed_err_o, timed_busy_o, gpio_out_o}, 5'h07)
    cmd_tog(2'h1);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h2)
    // chained timed runs restore the level before the first one
    cmd_lvl(2'h1, 1'b1);
    cmd_timed(2'h1, 1'b0, 7'h01);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h6)
    cmd_timed(2'h1, 1'b0, 7'h01);
    tick(9);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h6)
    tick();
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h3)
    // a level write cancels a running timed level for good
    cmd_timed(2'h1, 1'b1, 7'h05);
    cmd_lvl(2'h1, 1'b0);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h2)
    tick(12);
    `GOP_CHK({timed_busy_o, gpio_out_o}, 4'h2)
    // polarity by sensed level table
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 2; s++) begin
        sensor_lvl = s[0];
        cmd_pol(p[0]);
        tick(2);
        `GOP_CHK(occupancy_polarity_o, p[0])
        `GOP_CHK(ocs_level_o, s[0])
        `GOP_CHK(occupied_o, (s[0] == p[0]))
      end
    end
    // mid-run reset brings polarity back to active high
    cmd_pol(POL_ACTIVE_LOW);
    `GOP_CHK(occupancy_polarity_o, POL_ACTIVE_LOW)
    rst_b_i = 1'b0;
    tick(2);
    `GOP_CHK(occupancy_polarity_o, POL_ACTIVE_HIGH)
    `GOP_CHK({dir_o, gpio_out_o, timed_busy_o, occupied_o}, 7'h00)
    rst_b_i = 1'b1;
    cmd_lvl(2'h1, 1'b1);
    `GOP_CHK({gpio_oe_o, gpio_out_o}, 4'h1)
    end_sim();
  end
endmodule : tb_gop_pins
`default_nettype wire

// *** hdl/gop_pins.sv ***
// gpio pins with timed level and toggle, plus occupancy sensor input
`timescale 1ns/10ps
`default_nettype none
module gop_pins
  import gop_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic [NUM_PINS-1:0] dir_wr_i,
  input  wire logic                dir_val_i,
  input  wire logic [NUM_PINS-1:0] lvl_wr_i,
  input  wire logic                lvl_val_i,
  input  wire logic [NUM_PINS-1:0] timed_wr_i,
  input  wire logic                timed_val_i,
  input  wire logic [TIME_W-1:0]   timed_sec_i,
  input  wire logic [NUM_PINS-1:0] toggle_i,
  input  wire logic [NUM_PINS-1:0] gpio_in_i,
  input  wire logic                pol_wr_i,
  input  wire logic                pol_val_i,
  input  wire logic                ocs_in_i,
  output logic [NUM_PINS-1:0]      dir_o,
  output logic [NUM_PINS-1:0]      gpio_out_o,
  output logic [NUM_PINS-1:0]      gpio_oe_o,
  output logic [NUM_PINS-1:0]      pin_level_o,
  output logic [NUM_PINS-1:0]      timed_busy_o,
  output logic                     occupancy_polarity_o,
  output logic                     ocs_level_o,
  output logic                     occupied_o,
  output logic                     timed_err_o
);
  gop_pin_st_t [NUM_PINS-1:0] st_q, st_d;
  logic [NUM_PINS-1:0]        dir_q, dir_d;
  logic [NUM_PINS-1:0]        lvl_q, lvl_d;
  logic [NUM_PINS-1:0]        save_q, save_d;
  logic [TIME_W-1:0]          left_q [NUM_PINS];
  logic [TIME_W-1:0]          left_d [NUM_PINS];
  logic                       pol_q, pol_d;
  logic                       err_d;
  logic                       sec_tick;
  logic                       any_timed_start;

  // a duration outside 1 to 120 seconds is refused
  function automatic logic gop_time_ok(input logic [TIME_W-1:0] t);
    return (t >= TIME_MIN) && (t <= TIME_MAX);
  endfunction : gop_time_ok

  assign any_timed_start = |timed_wr_i && gop_time_ok(timed_sec_i);

  // seconds base restarts with each accepted timed command
  gop_sec_tick #(
    .SEC_CYCLES_P (SEC_CYCLES_P)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .restart_i  (any_timed_start),
    .tick_o     (sec_tick)
  );

  // per pin next state
  always_comb begin
    st_d   = st_q;
    dir_d  = dir_q;
    lvl_d  = lvl_q;
    save_d = save_q;
    err_d  = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      left_d[i] = left_q[i];
      if (dir_wr_i[i]) begin
        dir_d[i] = dir_val_i;
      end
      if (lvl_wr_i[i]) begin
        lvl_d[i] = lvl_val_i;
        st_d[i]  = GOP_ST_STEADY;
      end else if (timed_wr_i[i]) begin
        if (gop_time_ok(timed_sec_i)) begin
          save_d[i] = (st_q[i] == GOP_ST_TIMED) ? save_q[i] : lvl_q[i];
          lvl_d[i]  = timed_val_i;
          left_d[i] = timed_sec_i;
          st_d[i]   = GOP_ST_TIMED;
        end else begin
          err_d = 1'b1;
        end
      end else if (toggle_i[i]) begin
        lvl_d[i] = ~lvl_q[i];
        st_d[i]  = GOP_ST_STEADY;
      end else begin
        case (st_q[i])
          GOP_ST_TIMED: begin
            if (sec_tick) begin
              left_d[i] = left_q[i] - 1'b1;
              if (left_q[i] == TIME_MIN) begin
                lvl_d[i] = save_q[i];
                st_d[i]  = GOP_ST_STEADY;
              end
            end
          end
          default: begin
            st_d[i] = GOP_ST_STEADY;
          end
        endcase
      end
    end
    pol_d = pol_wr_i ? pol_val_i : pol_q;
  end

  // state registers and registered outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        st_q[i]   <= GOP_ST_STEADY;
        left_q[i] <= '0;
      end
      dir_q                <= {NUM_PINS{DIR_RESET}};
      lvl_q                <= {NUM_PINS{LEVEL_RESET}};
      save_q               <= {NUM_PINS{LEVEL_RESET}};
      pol_q                <= POL_RESET;
      dir_o                <= {NUM_PINS{DIR_RESET}};
      gpio_out_o           <= {NUM_PINS{LEVEL_RESET}};
      gpio_oe_o            <= '0;
      pin_level_o          <= '0;
      timed_busy_o         <= '0;
      occupancy_polarity_o <= POL_RESET;
      ocs_level_o          <= 1'b0;
      occupied_o           <= 1'b0;
      timed_err_o          <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        st_q[i]         <= st_d[i];
        left_q[i]       <= left_d[i];
        timed_busy_o[i] <= (st_d[i] == GOP_ST_TIMED);
      end
      dir_q                <= dir_d;
      lvl_q                <= lvl_d;
      save_q               <= save_d;
      pol_q                <= pol_d;
      dir_o                <= dir_d;
      gpio_out_o           <= lvl_d;
      gpio_oe_o            <= dir_d;
      pin_level_o          <= gpio_in_i;
      occupancy_polarity_o <= pol_d;
      ocs_level_o          <= ocs_in_i;
      occupied_o           <= (ocs_in_i == pol_d);
      timed_err_o          <= err_d;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  dir_report_a: assert property (dir_wr_i[0] |=> dir_o[0] == $past(dir_val_i))
    else $error("direction not reported");
  lvl_hold_a: assert property (gpio_oe_o[0] && !lvl_wr_i[0] && !timed_wr_i[0] && !toggle_i[0]
                               && st_q[0] == GOP_ST_STEADY |=> $stable(gpio_out_o[0]))
    else $error("steady level changed");
  lvl_set_a: assert property (lvl_wr_i[0] |=> gpio_out_o[0] == $past(lvl_val_i))
    else $error("level not applied");
  timed_set_a: assert property (timed_wr_i[0] && !lvl_wr_i[0] && gop_time_ok(timed_sec_i)
                                |=> gpio_out_o[0] == $past(timed_val_i) && timed_busy_o[0])
    else $error("timed level not applied");
  timed_bad_a: assert property (timed_wr_i[0] && !lvl_wr_i[0] && !gop_time_ok(timed_sec_i)
                                |=> timed_err_o && $stable(gpio_out_o[0]))
    else $error("bad duration accepted");
  toggle_inv_a: assert property (toggle_i[0] && !lvl_wr_i[0] && !timed_wr_i[0]
                                 |=> gpio_out_o[0] != $past(gpio_out_o[0]))
    else $error("toggle did not invert");
  ocs_level_a: assert property ($past(rst_b_i) |-> ocs_level_o == $past(ocs_in_i))
    else $error("sensed level wrong");
  pol_reset_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
                                !rst_b_i |=> occupancy_polarity_o == POL_ACTIVE_HIGH)
    else $error("polarity reset wrong");
  occ_map_a: assert property ($past(rst_b_i) |-> occupied_o == ($past(ocs_in_i) == occupancy_polarity_o))
    else $error("occupancy wrong");
  expire_a: assert property (st_q[0] == GOP_ST_TIMED && sec_tick && left_q[0] == TIME_MIN
                             && !lvl_wr_i[0] && !timed_wr_i[0] && !toggle_i[0]
                             |=> gpio_out_o[0] == $past(save_q[0]) && !timed_busy_o[0])
    else $error("expiry did not restore");

  // direction, drive enable and polarity writes
  oe_dir_a: assert property (gpio_oe_o == dir_o)
    else $error("drive enable differs from direction");
  pol_write_a: assert property (pol_wr_i |=> occupancy_polarity_o == $past(pol_val_i))
    else $error("polarity not written");
  // cancellation and chained timed runs
  cancel_lvl_a: assert property (lvl_wr_i[0] |=> !timed_busy_o[0])
    else $error("level write did not cancel");
  cancel_tog_a: assert property (toggle_i[0] && !lvl_wr_i[0] && !timed_wr_i[0]
                                 |=> !timed_busy_o[0])
    else $error("toggle did not cancel");
  chain_save_a: assert property (st_q[0] == GOP_ST_TIMED && timed_wr_i[0] && !lvl_wr_i[0]
                                 && gop_time_ok(timed_sec_i) |=> $stable(save_q[0]))
    else $error("chained run lost saved level");

  timed_run_c: cover property (timed_busy_o[0] ##1 !timed_busy_o[0]);
  toggle_c:    cover property (toggle_i[0] && gpio_oe_o[0]);
  occ_c:       cover property (occupied_o && occupancy_polarity_o == POL_ACTIVE_LOW);
  chain_c:     cover property (timed_busy_o[0] && timed_wr_i[0]);
endmodule : gop_pins
`default_nettype wire

// *** hdl/gop_pkg.sv ***
// constants shared by the gpio and occupancy block
package gop_pkg;
  localparam int unsigned NUM_PINS        = 2;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam int unsigned SEC_CNT_W       = 25;
  localparam int unsigned TIME_W          = 7;
  localparam logic [6:0]  TIME_MIN        = 7'h01;
  localparam logic [6:0]  TIME_MAX        = 7'h78;
  localparam logic        DIR_INPUT       = 1'b0;
  localparam logic        DIR_OUTPUT      = 1'b1;
  localparam logic        POL_ACTIVE_LOW  = 1'b0;
  localparam logic        POL_ACTIVE_HIGH = 1'b1;
  localparam logic        POL_RESET       = POL_ACTIVE_HIGH;
  localparam logic        LEVEL_RESET     = 1'b0;
  localparam logic        DIR_RESET       = DIR_INPUT;
  typedef enum logic [1:0] {
    GOP_ST_STEADY = 2'b01,
    GOP_ST_TIMED  = 2'b10
  } gop_pin_st_t;
endpackage : gop_pkg

// *** hdl/gop_sec_tick.sv ***
// one-second enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module gop_sec_tick
  import gop_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  logic [SEC_CNT_W-1:0] cnt_q;
  logic [SEC_CNT_W-1:0] cnt_d;
  logic                 tick_d;
  // count down one second, restart on request
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q - 1'b1;
    // tick register adds one cycle, so a restart loads one count less
    if (restart_i) begin
      cnt_d = SEC_CNT_W'(SEC_CYCLES_P - 2);
    end else if (cnt_q == '0) begin
      cnt_d  = SEC_CNT_W'(SEC_CYCLES_P - 1);
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cnt_q  <= SEC_CNT_W'(SEC_CYCLES_P - 1);
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule : gop_sec_tick
`default_nettype wire
